// >>> common/gic_regs.svh
/*
 * register offsets, bit positions and reset values of the global interrupt block.
 * assumes an 8-bit internal register port with byte addresses.
 */
`ifndef GIC_REGS_SVH
`define GIC_REGS_SVH
`define GIC_ADDR_FLAGS     8'h01
`define GIC_ADDR_ENABLES   8'h02
`define GIC_ENABLES_RST    8'h00
`define GIC_FLAGS_RST      8'h00
`define GIC_BIT_WATCHDOG   7
`define GIC_BIT_OVERTEMP   6
`define GIC_BIT_SUPPLY     5
`define GIC_BIT_CONVERTER  4
`define GIC_BIT_HALFBRIDGE 3
`define GIC_BIT_HIGHSIDE   2
`define GIC_BIT_MIRROR     1
`define GIC_BIT_LINPHY     0
`define GIC_NUM_SRC        8
`endif

// >>> common/gic_pkg.sv
/*
 * types shared by the global interrupt block.
 * assumes gic_regs.svh supplies the numeric constants.
 */
`include "gic_regs.svh"
package gic_pkg;
    typedef logic [`GIC_NUM_SRC-1:0] gic_vec_t;
endpackage : gic_pkg

// >>> design/gic_flag_cell.sv
/*
 * one sticky event flag with write-one and alternate clear.
 * assumes all inputs synchronous to sys_clk_i.
 */
`timescale 1ns/100ps
module gic_flag_cell (
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    input  wire logic event_i,
    input  wire logic clear_i,
    output logic      flag_o
);
    logic flag_reg;
    logic flag_next;

    // set beats clear, and a present cause keeps the flag up
    always_comb begin
        flag_next = flag_reg;
        if (clear_i) begin
            flag_next = 1'b0;
        end
        if (event_i) begin
            flag_next = 1'b1;
        end
    end

    // flag storage
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_o = flag_reg;
endmodule : gic_flag_cell

// >>> design/gic_global_irq.sv
/*
 * global interrupt logic: eight grouped flags, enables, active-low host line.
 * assumes a synchronous 8-bit register port from the spi slave and
 * event/peripheral flag levels from the peripherals, all on sys_clk_i.
 */
// What this block does
// [RQ1] enabled source event pulls host line low
// [RQ2] all enables zero after reset
// [RQ3] event sets flag, held until cleared
// [RQ4] flags set even when source disabled
// [RQ5] write one to flag bit clears it
// [RQ6] grouped flag drops when peripheral flags clear
// [RQ7] clear ignored while cause still present
// [RQ8] converter result read clears done flag
// [RQ9] watchdog flag clears only via watchdog clear
// [RQ10] enable register at 0x02, bit order fixed
// [RQ11] read-only flag register at 0x01
// [RQ12] watchdog raises interrupt only in standby
// [RQ13] overtemp shuts drivers regardless of enable
// [RQ14] mirror flag in diag reg, mirrored bit 1
// [RQ15] enabled flags or-reduced onto active-low line
// [RQ16] grouped flag is or of peripheral flags
// [RQ17] line returns high when no enabled flag
`timescale 1ns/100ps
`include "gic_regs.svh"
module gic_global_irq
    import gic_pkg::*;
#(
    parameter int SUPPLY_N = 3,
    parameter int CONV_N   = 2,
    parameter int HB_N     = 4,
    parameter int HS_N     = 4,
    parameter int LIN_N    = 3
) (
    input  wire logic                sys_clk_i,
    input  wire logic                srst_i,
    // register port
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic [7:0]          reg_wdata_i,
    output logic      [7:0]          reg_rdata_o,
    // peripheral flag levels forming the grouped sources
    input  wire logic                watchdog_timeout_i,
    input  wire logic                watchdog_clear_i,
    input  wire logic                standby_i,
    input  wire logic                overtemp_flag_i,
    input  wire logic [SUPPLY_N-1:0] supply_err_flags_i,
    input  wire logic                conversion_done_i,
    input  wire logic                conv_result_read_i,
    input  wire logic                conv_done_clear_i,
    input  wire logic [CONV_N-2:0]   conv_other_flags_i,
    input  wire logic [HB_N-1:0]     halfbridge_oc_flags_i,
    input  wire logic [HS_N-1:0]     highside_oc_flags_i,
    input  wire logic                mirror_oc_event_i,
    input  wire logic                mirror_oc_clear_i,
    input  wire logic [LIN_N-1:0]    linphy_flags_i,
    // outputs
    output logic                     conversion_done_flag_o,
    output logic                     mirror_diag_oc_o,
    output logic                     driver_shutdown_o,
    output logic                     host_irq_n_o
);
    // refuse group sizes the port slices cannot carry
    generate
        if (SUPPLY_N < 1 || CONV_N < 2 || HB_N < 1 || HS_N < 1 || LIN_N < 1) begin : g_bad_size
            $error("gic_global_irq: group sizes out of range");
        end
    endgenerate

    logic [7:0] global_event_enables_reg;
    logic [7:0] reg_rdata_reg;
    logic       irq_n_reg;
    logic       watchdog_flag;
    logic       conversion_done_flag;
    logic       mirror_oc_flag;
    gic_vec_t   global_event_flags;
    gic_vec_t   enabled_flags;
    logic       wr_flags;
    logic       watchdog_event;

    assign wr_flags = reg_wr_i && (reg_addr_i == `GIC_ADDR_FLAGS);

    // enable register; only this register stores written data
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            global_event_enables_reg <= `GIC_ENABLES_RST; // [RQ2]
        end else if (reg_wr_i && reg_addr_i == `GIC_ADDR_ENABLES) begin
            global_event_enables_reg <= reg_wdata_i; // [RQ10]
        end
    end

    // watchdog timeout counts only in standby; write-one has no effect on it
    assign watchdog_event = watchdog_timeout_i && standby_i; // [RQ12]
    gic_flag_cell u_watchdog (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .event_i   (watchdog_event),
        .clear_i   (watchdog_clear_i), // [RQ9]
        .flag_o    (watchdog_flag)
    );

    // converter done flag: write-one in its own register or a result read
    gic_flag_cell u_conv_done (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .event_i   (conversion_done_i), // [RQ3] [RQ4]
        .clear_i   (conv_done_clear_i || conv_result_read_i), // [RQ8] [RQ5]
        .flag_o    (conversion_done_flag)
    );

    // mirror over-current flag lives in the mirror diag register
    gic_flag_cell u_mirror (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .event_i   (mirror_oc_event_i), // [RQ7]
        .clear_i   (mirror_oc_clear_i), // [RQ5]
        .flag_o    (mirror_oc_flag)
    );

    // grouped flags are plain or of peripheral flags, so a write-one to them
    // is swallowed and they fall only when the whole group is clear
    always_comb begin
        global_event_flags = '0;
        global_event_flags[`GIC_BIT_WATCHDOG]   = watchdog_flag;
        global_event_flags[`GIC_BIT_OVERTEMP]   = overtemp_flag_i;
        global_event_flags[`GIC_BIT_SUPPLY]     = |supply_err_flags_i; // [RQ16] [RQ6]
        global_event_flags[`GIC_BIT_CONVERTER]  = conversion_done_flag
                                                 | (|conv_other_flags_i); // [RQ16]
        global_event_flags[`GIC_BIT_HALFBRIDGE] = |halfbridge_oc_flags_i; // [RQ16]
        global_event_flags[`GIC_BIT_HIGHSIDE]   = |highside_oc_flags_i; // [RQ16]
        global_event_flags[`GIC_BIT_MIRROR]     = mirror_oc_flag; // [RQ14]
        global_event_flags[`GIC_BIT_LINPHY]     = |linphy_flags_i; // [RQ16]
    end

    // per-source gating, one enable per flag
    genvar g;
    generate
        for (g = 0; g < `GIC_NUM_SRC; g++) begin : g_gate
            assign enabled_flags[g] = global_event_flags[g]
                                      & global_event_enables_reg[g]; // [RQ1]
        end
    endgenerate

    // registered line; deasserts the cycle after the last enabled flag falls
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_n_reg <= 1'b1;
        end else begin
            irq_n_reg <= ~(|enabled_flags); // [RQ15] [RQ17] [RQ1]
        end
    end

    // read data registered one cycle after the read strobe
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `GIC_ADDR_FLAGS:   reg_rdata_reg <= global_event_flags; // [RQ11]
                `GIC_ADDR_ENABLES: reg_rdata_reg <= global_event_enables_reg; // [RQ10]
                default:           reg_rdata_reg <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_o = reg_rdata_reg;
    assign host_irq_n_o = irq_n_reg;
    assign conversion_done_flag_o = conversion_done_flag;
    assign mirror_diag_oc_o = mirror_oc_flag;
    // drivers cut on overtemp irrespective of the enable bit
    assign driver_shutdown_o = overtemp_flag_i; // [RQ13]

    // the write-one to the flag register clears nothing here; grouped bits
    // follow their peripheral registers
    logic unused_wr;
    assign unused_wr = wr_flags;
endmodule : gic_global_irq

// >>> testbench/gic_checker.sv
/* port checker for gic_global_irq, bound below.
   assumes one clock and the synchronous active-high reset. */
`timescale 1ns/100ps
module gic_checker (
    input wire logic       sys_clk_i,
    input wire logic       srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       overtemp_flag_i,
    input wire logic       conversion_done_i,
    input wire logic       conv_result_read_i,
    input wire logic       conv_done_clear_i,
    input wire logic       conversion_done_flag_o,
    input wire logic       driver_shutdown_o,
    input wire logic       host_irq_n_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // read of the flag register, data lands one edge later
    wire rdf = reg_rd_i && reg_addr_i == 8'h01;
    property p_ot_rd; rdf |=> reg_rdata_o[6] == $past(overtemp_flag_i); endproperty
    a_ot_rd: assert property (p_ot_rd) else $error("overtemp read");
    property p_unmap; reg_rd_i && reg_addr_i > 8'h02 |=> reg_rdata_o == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_shut; driver_shutdown_o == overtemp_flag_i; endproperty
    a_shut: assert property (p_shut) else $error("shutdown");
    property p_set; conversion_done_i |=> conversion_done_flag_o; endproperty
    a_set: assert property (p_set) else $error("done not set");
    property p_hold; conversion_done_flag_o && !conv_result_read_i && !conv_done_clear_i
        |=> conversion_done_flag_o; endproperty
    a_hold: assert property (p_hold) else $error("done lost");
    property p_rdclr; conv_result_read_i && !conversion_done_i |=> !conversion_done_flag_o;
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("read clear");
    property p_clr; conv_done_clear_i && !conversion_done_i |=> !conversion_done_flag_o;
    endproperty
    a_clr: assert property (p_clr) else $error("write clear");
    // enables start at zero, so the line stays high
    property p_rst; $fell(srst_i) |-> host_irq_n_o [*2]; endproperty
    a_rst: assert property (p_rst) else $error("irq after reset");
    c_irq: cover property ($fell(host_irq_n_o));
    c_clr: cover property ($fell(conversion_done_flag_o));
    c_ot: cover property (rdf ##1 reg_rdata_o[6]);
endmodule : gic_checker
bind gic_global_irq gic_checker i_chk (.*);

// >>> testbench/gic_host_model.sv
/* host side: byte register master of the interrupt block.
   assumes calls start just after a clock edge. */
`timescale 1ns/100ps
module gic_host_model (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_wdata_o
);
    initial {reg_addr_o, reg_wr_o, reg_rd_o, reg_wdata_o} = '0;
    // one strobe edge; idle bus parks inverted so stale values never match
    task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge sys_clk_i);
        #1;
        {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {w, !w, a, d};
        @(posedge sys_clk_i);
        #1;
        {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'b00, ~a, ~d};
        q = reg_rdata_i;
    endtask : acc
endmodule : gic_host_model

// >>> testbench/gic_global_irq_tb.sv
/* bench for gic_global_irq: events in, flags, enables and line checked.
   assumes default group widths and gic_host_model for registers. */
`timescale 1ns/100ps
module gic_global_irq_tb;
    logic        clk = 0;
    logic        srst = 1;
    logic [23:0] ev = '0;
    logic [7:0]  addr, wdat, rdat, q;
    logic        wr, rd, irq_n, done_f, mir_f, shut_f;
    int          n_errors = 0;
    int          n_tests = 0;
    int          evb[6] = '{3, 9, 12, 13, 17, 21};
    logic [7:0]  fx[6] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
    always #10 clk = ~clk;
    // ev: 0 wdt, 1 wdt clr, 2 standby, 3 ot, 4 done, 5 result rd, 6 done clr, 7/8 mirror
    gic_host_model i_host (.sys_clk_i(clk), .reg_rdata_i(rdat), .reg_addr_o(addr),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdat));
    gic_global_irq i_dut (.sys_clk_i(clk), .srst_i(srst), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdat), .reg_rdata_o(rdat),
        .watchdog_timeout_i(ev[0]), .watchdog_clear_i(ev[1]), .standby_i(ev[2]),
        .overtemp_flag_i(ev[3]), .supply_err_flags_i(ev[11:9]), .conversion_done_i(ev[4]),
        .conv_result_read_i(ev[5]), .conv_done_clear_i(ev[6]), .conv_other_flags_i(ev[12]),
        .halfbridge_oc_flags_i(ev[16:13]), .highside_oc_flags_i(ev[20:17]),
        .mirror_oc_event_i(ev[7]), .mirror_oc_clear_i(ev[8]), .linphy_flags_i(ev[23:21]),
        .conversion_done_flag_o(done_f), .mirror_diag_oc_o(mir_f), .driver_shutdown_o(shut_f),
        .host_irq_n_o(irq_n));
    task automatic chk(input string s, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // one-cycle event, then two edges for flag and line to settle
    task automatic pulse(input int b);
        ev[b] = 1;
        tick(1);
        ev[b] = 0;
        tick(2);
    endtask : pulse
    task automatic rdc(input logic [7:0] a, e);
        i_host.acc(0, a, 8'h00, q);
        chk("register", e, q);
    endtask : rdc
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // watchdog: the whole run needs well under 20 us
    initial begin
        #40us;
        n_errors++;
        tally_and_finish;
    end
    initial begin
        tick(10);
        srst = 0;
        chk("irq_n", 8'h01, {7'h0, irq_n});
        rdc(8'h01, 8'h00);
        rdc(8'h02, 8'h00);
        i_host.acc(1, 8'h02, 8'ha5, q);
        rdc(8'h02, 8'ha5);
        i_host.acc(1, 8'h01, 8'hff, q);
        rdc(8'h01, 8'h00);
        rdc(8'h07, 8'h00);
        $display("registers test done");
        // level groups, first disabled then enabled
        for (int k = 0; k < 2; k++) begin
            i_host.acc(1, 8'h02, k ? 8'hff : 8'h00, q);
            for (int i = 0; i < 6; i++) begin
                ev[evb[i]] = 1;
                tick(2);
                chk("irq_n", {7'h0, k == 0}, {7'h0, irq_n});
                rdc(8'h01, fx[i]);
                chk("shutdown", {7'h0, i == 0}, {7'h0, shut_f});
                ev[evb[i]] = 0;
                tick(2);
                chk("irq_n", 8'h01, {7'h0, irq_n});
            end
        end
        $display("groups test done");
        pulse(4);
        rdc(8'h01, 8'h10);
        chk("irq_n", 8'h00, {7'h0, irq_n});
        pulse(5);
        chk("irq_n", 8'h01, {7'h0, irq_n});
        ev[4] = 1;
        pulse(6);
        chk("done", 8'h01, {7'h0, done_f});
        ev[4] = 0;
        pulse(6);
        chk("done", 8'h00, {7'h0, done_f});
        pulse(7);
        rdc(8'h01, 8'h02);
        chk("mirror_diag", 8'h01, {7'h0, mir_f});
        pulse(8);
        rdc(8'h01, 8'h00);
        chk("mirror_diag", 8'h00, {7'h0, mir_f});
        $display("sticky test done");
        pulse(0);
        rdc(8'h01, 8'h00);
        ev[2] = 1;
        pulse(0);
        i_host.acc(1, 8'h01, 8'h80, q);
        rdc(8'h01, 8'h80);
        pulse(1);
        rdc(8'h01, 8'h00);
        $display("watchdog test done");
        tally_and_finish;
    end
endmodule : gic_global_irq_tb
